// File: hw/display_mem.sv
// display memory: one bit per segment, read data registered
// assumes byte writes from the data-memory port on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "paged_stack_defs.svh"

module display_mem #(
    parameter int BYTES = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wrEn,
    input wire logic [$clog2(BYTES)-1:0] addr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    output logic [BYTES*8-1:0] segments
);
    initial begin
        if (BYTES < 2) $error("display_mem needs at least two bytes");
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            segments <= '0;
            rdData <= 8'h00;
        end else begin
            if (wrEn) begin
                segments[addr*8 +: 8] <= wrData;
            end
            rdData <= segments[addr*8 +: 8];
        end
    end
endmodule : display_mem
`default_nettype wire

// File: hw/page_mux.sv
// page section selection and physical address forming
// assumes page registers and stack page come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
`include "paged_stack_defs.svh"

module page_mux
    import paged_stack_pkg::*;
(
    input wire logic bankedMode,
    input wire page_sel_e pageSel,
    input wire logic [7:0] expandPage,
    input wire logic [7:0] indexXPage,
    input wire logic [7:0] indexYPage,
    input wire logic [7:0] stackPageInput,
    input wire logic [15:0] logicalAddr,
    output logic [23:0] physAddr
);
    logic [7:0] page;

    always_comb begin
        case (pageSel)
            PAGE_EXPAND: page = expandPage;
            PAGE_IX: page = indexXPage;
            PAGE_IY: page = indexYPage;
            PAGE_STACK: page = stackPageInput;
            default: page = expandPage;
        endcase
        // flat models keep one 64K space; stack page still passes through
        if (!bankedMode && pageSel != PAGE_STACK) begin
            page = `FLAT_PAGE;
        end
        physAddr = {page, logicalAddr};
    end
endmodule : page_mux
`default_nettype wire

// File: hw/paged_stack_defs.svh
// constants for the paged data memory and stack unit
// assumes inclusion by bare name from package and design files
`ifndef PAGED_STACK_DEFS_SVH
`define PAGED_STACK_DEFS_SVH

`define PAGE_W 8
`define LOGICAL_W 16
`define PHYS_W 24
`define SP_STEP 16'h0001
`define SKIP_ADD 16'h0002
`define FLAT_PAGE 8'h00
`define CALL_BYTES_MAX 3'h3
`define CALL_BYTES_MIN 3'h2
`define EXC_BYTES_MAX 3'h4
`define EXC_BYTES_MIN 3'h3
`define RESET_PAGE 8'h00
`define DISP_W 64

`endif

// File: hw/paged_stack_pkg.sv
// types for the paged data memory and stack unit
// assumes paged_stack_defs.svh on the include path
`include "paged_stack_defs.svh"

package paged_stack_pkg;

    // addressing mode page selector
    typedef enum logic [1:0] {
        PAGE_EXPAND = 2'h0,
        PAGE_IX = 2'h1,
        PAGE_IY = 2'h2,
        PAGE_STACK = 2'h3
    } page_sel_e;

    // stack operation commands
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_PUSH8 = 4'h1,
        OP_POP8 = 4'h2,
        OP_CALL = 4'h3,
        OP_RET = 4'h4,
        OP_SKIPRET = 4'h5,
        OP_EXC = 4'h6,
        OP_EXCRET = 4'h7,
        OP_PUSHALL = 4'h8,
        OP_POPALL = 4'h9,
        OP_PUSHALE = 4'ha,
        OP_POPALE = 4'hb
    } stack_op_e;

    // one-hot sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PUSH = 4'h2,
        ST_POPRD = 4'h4,
        ST_DONE = 4'h8
    } seq_state_e;

endpackage : paged_stack_pkg

// File: hw/paged_stack_unit.sv
// paged data-memory addressing and hardware stack sequencer
// assumes a one-byte-per-cycle memory port on sys_clk, read data next cycle
`timescale 1ns/1ns
`default_nettype none
`include "paged_stack_defs.svh"

module paged_stack_unit
    import paged_stack_pkg::*;
#(
    parameter int DISP_BYTES = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic bankedMode,
    input wire logic maxMode,
    input wire logic [7:0] stackPageInput,
    input wire logic [7:0] expandPageIn,
    input wire logic [7:0] indexXPageIn,
    input wire logic [7:0] indexYPageIn,
    input wire logic pageLoad,
    input wire logic spLoad,
    input wire logic [15:0] spLoadValue,
    input wire stack_op_e opCode,
    input wire logic opValid,
    input wire logic [7:0] push8Data,
    input wire logic [15:0] pcIn,
    input wire logic [7:0] codeBankIn,
    input wire logic [7:0] flagsIn,
    input wire logic [63:0] bulkRegsIn,
    input wire logic [7:0] memRdData,
    input wire logic dataReq,
    input wire logic dataWrite,
    input wire page_sel_e dataPageSel,
    input wire logic [15:0] dataAddr,
    input wire logic [7:0] dataWrData,
    output logic opBusy,
    output logic opDone,
    output logic [23:0] memAddr,
    output logic [7:0] memWrData,
    output logic memWr,
    output logic memRd,
    output logic [15:0] stackPointer,
    output logic [15:0] pcOut,
    output logic [7:0] codeBankOut,
    output logic [7:0] flagsOut,
    output logic [7:0] pop8Data,
    output logic [63:0] bulkRegsOut,
    output logic restoreFlags,
    output logic restoreBank,
    output logic [7:0] dispRdData,
    output logic [DISP_BYTES*8-1:0] segments
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        seq_state_e st;
        stack_op_e op;
        logic [15:0] sp;
        logic [7:0] expandPage;
        logic [7:0] indexXPage;
        logic [7:0] indexYPage;
        logic [87:0] buf88;
        logic [3:0] left;
        logic [3:0] total;
        logic [23:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
        logic rdPipe;
        logic busy;
        logic done;
        logic [15:0] pc;
        logic [7:0] cb;
        logic [7:0] flags;
        logic [7:0] pop8;
        logic [63:0] bulk;
        logic rFlags;
        logic rBank;
    } state_s;

    state_s q, d;
    logic [23:0] dataPhys;
    logic [23:0] stackPhys;
    logic dispHit;
    logic [3:0] nBytes;
    logic [87:0] pushImage;
    logic [15:0] spDec;

    initial begin
        if (DISP_BYTES < 2 || DISP_BYTES > 256) $error("DISP_BYTES out of range");
    end

    // ************************************************
    // address forming
    // ************************************************
    page_mux dataMux (
        .bankedMode(bankedMode),
        .pageSel(dataPageSel),
        .expandPage(q.expandPage),
        .indexXPage(q.indexXPage),
        .indexYPage(q.indexYPage),
        .stackPageInput(stackPageInput),
        .logicalAddr(dataAddr),
        .physAddr(dataPhys)
    );

    // display memory sits at the top of page zero
    assign dispHit = dataReq && dataWrite && dataPhys[23:8] == 16'h00ff
        && dataPhys[7:0] < 8'(DISP_BYTES);

    display_mem #(.BYTES(DISP_BYTES)) dispMem (
        .sys_clk(sys_clk),
        .srst(srst),
        .wrEn(dispHit),
        .addr(dataPhys[$clog2(DISP_BYTES)-1:0]),
        .wrData(dataWrData),
        .rdData(dispRdData),
        .segments(segments)
    );

    assign spDec = q.sp - `SP_STEP;
    assign stackPhys = {stackPageInput, spDec};

    // ************************************************
    // push images, first byte in the low lane
    // ************************************************
    always_comb begin
        pushImage = '0;
        nBytes = 4'h0;
        case (opCode)
            OP_PUSH8: begin
                pushImage[7:0] = push8Data;
                nBytes = 4'h1;
            end
            OP_CALL: begin
                if (bankedMode && maxMode) begin
                    pushImage[23:0] = {pcIn[7:0], pcIn[15:8], codeBankIn};
                    nBytes = {1'b0, `CALL_BYTES_MAX};
                end else begin
                    pushImage[15:0] = {pcIn[7:0], pcIn[15:8]};
                    nBytes = {1'b0, `CALL_BYTES_MIN};
                end
            end
            OP_EXC: begin
                if (bankedMode && maxMode) begin
                    pushImage[31:0] = {flagsIn, pcIn[7:0], pcIn[15:8], codeBankIn};
                    nBytes = {1'b0, `EXC_BYTES_MAX};
                end else begin
                    pushImage[23:0] = {flagsIn, pcIn[7:0], pcIn[15:8]};
                    nBytes = {1'b0, `EXC_BYTES_MIN};
                end
            end
            OP_PUSHALL, OP_PUSHALE: begin
                // bulkRegsIn[55:0] byte-reversed in bits 55:0, base in bits 63:56
                pushImage[63:0] = {bulkRegsIn[63:56],
                    bulkRegsIn[7:0], bulkRegsIn[15:8], bulkRegsIn[23:16],
                    bulkRegsIn[31:24], bulkRegsIn[39:32], bulkRegsIn[47:40],
                    bulkRegsIn[55:48]};
                nBytes = 4'h8;
                pushImage = {pushImage[71:0], 16'h0000} >> 16;
                pushImage[63:0] = {bulkRegsIn[63:56], bulkRegsIn[7:0],
                    bulkRegsIn[15:8], bulkRegsIn[23:16], bulkRegsIn[31:24],
                    bulkRegsIn[39:32], bulkRegsIn[47:40], bulkRegsIn[55:48]};
                pushImage[71:64] = 8'h00;
                if (opCode == OP_PUSHALE && bankedMode) begin
                    pushImage[87:64] = {q.indexYPage, q.indexXPage, q.expandPage};
                    nBytes = 4'hb;
                end else begin
                    nBytes = 4'h8;
                end
            end
            default: begin
                pushImage = '0;
                nBytes = 4'h0;
            end
        endcase
    end

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.rdPipe = q.rd;
        d.done = 1'b0;
        d.rFlags = 1'b0;
        d.rBank = 1'b0;
        if (pageLoad && bankedMode) begin
            d.expandPage = expandPageIn;
            d.indexXPage = indexXPageIn;
            d.indexYPage = indexYPageIn;
        end
        if (spLoad && q.st == ST_IDLE) begin
            d.sp = spLoadValue;
        end
        case (q.st)
            ST_IDLE: begin
                d.busy = 1'b0;
                if (opValid && !spLoad) begin
                    d.op = opCode;
                    d.busy = 1'b1;
                    d.buf88 = pushImage;
                    d.left = nBytes;
                    case (opCode)
                        OP_PUSH8, OP_CALL, OP_EXC, OP_PUSHALL, OP_PUSHALE: begin
                            d.st = ST_PUSH;
                        end
                        OP_POP8: begin
                            d.left = 4'h1;
                            d.st = ST_POPRD;
                        end
                        OP_RET, OP_SKIPRET: begin
                            d.left = (bankedMode && maxMode) ? 4'h3 : 4'h2;
                            d.st = ST_POPRD;
                        end
                        OP_EXCRET: begin
                            d.left = (bankedMode && maxMode) ? 4'h4 : 4'h3;
                            d.st = ST_POPRD;
                        end
                        OP_POPALL: begin
                            d.left = 4'h8;
                            d.st = ST_POPRD;
                        end
                        OP_POPALE: begin
                            d.left = bankedMode ? 4'hb : 4'h8;
                            d.st = ST_POPRD;
                        end
                        default: begin
                            d.busy = 1'b0;
                        end
                    endcase
                    d.total = d.left;
                    d.buf88 = (d.st == ST_POPRD) ? '0 : pushImage;
                end
            end
            ST_PUSH: begin
                // last pushed byte sits lowest; pop reverses the order
                d.sp = spDec;
                d.addr = stackPhys;
                d.wrData = q.buf88[7:0];
                d.wr = 1'b1;
                d.buf88 = q.buf88 >> 8;
                d.left = q.left - 4'h1;
                if (q.left == 4'h1) begin
                    d.st = ST_DONE;
                end
            end
            ST_POPRD: begin
                // read data lands one cycle after the strobe; one byte in flight
                if (q.rdPipe) begin
                    d.buf88 = {q.buf88[79:0], memRdData};
                    d.left = q.left - 4'h1;
                end
                if (q.rdPipe && q.left == 4'h1) begin
                    d.st = ST_DONE;
                end else if (!q.rd) begin
                    d.addr = {stackPageInput, q.sp};
                    d.rd = 1'b1;
                    d.sp = q.sp + `SP_STEP;
                end
            end
            ST_DONE: begin
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = ST_IDLE;
                // pops gathered first byte highest in buf88
                case (q.op)
                    OP_POP8: d.pop8 = q.buf88[7:0];
                    OP_RET, OP_SKIPRET, OP_EXCRET: begin
                        // code bank was pushed first, so it is read last
                        if (bankedMode && maxMode) begin
                            d.cb = q.buf88[7:0];
                            d.pc = {q.buf88[15:8], q.buf88[23:16]};
                            if (q.op == OP_EXCRET) begin
                                d.flags = q.buf88[31:24];
                                d.rFlags = 1'b1;
                            end
                        end else begin
                            d.pc = {q.buf88[7:0], q.buf88[15:8]};
                            if (q.op == OP_EXCRET) begin
                                d.flags = q.buf88[23:16];
                                d.rFlags = 1'b1;
                            end
                        end
                        d.rBank = bankedMode && maxMode;
                        if (q.op == OP_SKIPRET) begin
                            d.pc = d.pc + `SKIP_ADD;
                        end
                    end
                    OP_POPALL, OP_POPALE: begin
                        if (q.total == 4'hb) begin
                            d.indexYPage = q.buf88[87:80];
                            d.indexXPage = q.buf88[79:72];
                            d.expandPage = q.buf88[71:64];
                        end
                        d.bulk = {q.buf88[63:56], q.buf88[7:0], q.buf88[15:8],
                            q.buf88[23:16], q.buf88[31:24], q.buf88[39:32],
                            q.buf88[47:40], q.buf88[55:48]};
                    end
                    default: d.pop8 = q.pop8;
                endcase
            end
            default: d.st = ST_IDLE;
        endcase
        if (q.st == ST_IDLE && dataReq) begin
            d.addr = dataPhys;
            d.wrData = dataWrData;
            d.wr = dataWrite;
            d.rd = !dataWrite;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.expandPage <= `RESET_PAGE;
            q.indexXPage <= `RESET_PAGE;
            q.indexYPage <= `RESET_PAGE;
        end else begin
            q <= d;
        end
    end

    assign opBusy = q.busy;
    assign opDone = q.done;
    assign memAddr = q.addr;
    assign memWrData = q.wrData;
    assign memWr = q.wr;
    assign memRd = q.rd;
    assign stackPointer = q.sp;
    assign pcOut = q.pc;
    assign codeBankOut = q.cb;
    assign flagsOut = q.flags;
    assign pop8Data = q.pop8;
    assign bulkRegsOut = q.bulk;
    assign restoreFlags = q.rFlags;
    assign restoreBank = q.rBank;

    // ************************************************
    // checks
    // ************************************************
    a_push_predec: assert property (@(posedge sys_clk) disable iff (srst)
        q.st == ST_PUSH |=> memWr && memAddr[15:0] == $past(q.sp) - 16'h0001)
        else $error("push not pre-decremented");
    a_pop_postinc: assert property (@(posedge sys_clk) disable iff (srst)
        (q.st == ST_POPRD && d.rd && d.addr[15:0] == q.sp) |=> stackPointer ==
        $past(q.sp) + 16'h0001) else $error("pop not post-incremented");
    a_stack_page: assert property (@(posedge sys_clk) disable iff (srst)
        q.st == ST_PUSH |=> memAddr[23:16] == $past(stackPageInput))
        else $error("stack page not on upper address");
    a_skip_add: assert property (@(posedge sys_clk) disable iff (srst)
        (q.st == ST_DONE && q.op == OP_SKIPRET) |=>
        pcOut == ($past(bankedMode && maxMode) ?
        {$past(q.buf88[15:8]), $past(q.buf88[23:16])} :
        {$past(q.buf88[7:0]), $past(q.buf88[15:8])}) + 16'h0002)
        else $error("skip return offset wrong");
    a_flag_restore: assert property (@(posedge sys_clk) disable iff (srst)
        restoreFlags |-> $past(q.op) == OP_EXCRET) else $error("flags restored wrongly");
    a_call_count: assert property (@(posedge sys_clk) disable iff (srst)
        (q.st == ST_IDLE && opValid && !spLoad && opCode == OP_CALL && bankedMode
        && maxMode) |=> q.left == 4'h3) else $error("call byte count wrong");
    a_flat_page: assert property (@(posedge sys_clk) disable iff (srst)
        (q.st == ST_IDLE && dataReq && !bankedMode && dataPageSel != PAGE_STACK)
        |=> memAddr[23:16] == 8'h00) else $error("flat model used a page");
    a_page_sel: assert property (@(posedge sys_clk) disable iff (srst)
        (q.st == ST_IDLE && dataReq && bankedMode && dataPageSel == PAGE_IX)
        |=> memAddr == {$past(q.indexXPage), $past(dataAddr)})
        else $error("index x page not selected");
endmodule : paged_stack_unit
`default_nettype wire

// File: testbench/stack_mem_model.sv
// far-side byte memory behind the stack unit's memory port
// assumes read data is wanted in the cycle after memRd
`timescale 1ns/1ns
`default_nettype none

module stack_mem_model (
    input wire logic sys_clk,
    input wire logic [23:0] memAddr,
    input wire logic [7:0] memWrData,
    input wire logic memWr,
    input wire logic memRd,
    output logic [7:0] memRdData
);
    logic [7:0] mem [int];

    initial memRdData = 8'h00;

    always @(posedge sys_clk) begin
        if (memWr) begin
            mem[int'(memAddr)] = memWrData;
        end
        if (memRd) begin
            memRdData <= mem.exists(int'(memAddr)) ? mem[int'(memAddr)] : ~memAddr[7:0];
        end else begin
            // released bus: never leave the last byte standing
            memRdData <= ~memRdData;
        end
    end
endmodule : stack_mem_model

`default_nettype wire

// File: testbench/tb_paged_stack_unit.sv
// scenario bench for the paged stack unit
// assumes stack_mem_model as the memory behind the unit
`timescale 1ns/1ns
`default_nettype none

module tb_paged_stack_unit
    import paged_stack_pkg::*;
;
    logic sys_clk = 1'b0, srst = 1'b1, bankedMode = 1'b0, maxMode = 1'b0;
    logic pageLoad = 1'b0, spLoad = 1'b0, opValid = 1'b0, dataReq = 1'b0, dataWrite = 1'b0;
    logic [7:0] stackPage = 8'h5a, epIn = 8'h11, xpIn = 8'h22, ypIn = 8'h33;
    logic [7:0] push8Data = 8'h00, codeBankIn = 8'h00, flagsIn = 8'h00, dataWrData = 8'h00;
    logic [15:0] spLoadValue = 16'h0000, pcIn = 16'h0000, dataAddr = 16'h0000, spAll;
    logic [63:0] bulkRegsIn = 64'h0;
    stack_op_e opCode = OP_NONE;
    page_sel_e dataPageSel = PAGE_EXPAND;
    logic opBusy, opDone, memWr, memRd, restoreFlags, restoreBank;
    logic [23:0] memAddr;
    logic [7:0] memWrData, memRdData, codeBankOut, flagsOut, pop8Data;
    logic [15:0] stackPointer, pcOut;
    logic [63:0] bulkRegsOut, segments;
    int n_errors = 0, n_tests = 0, cycles = 0;

    always #4 sys_clk = ~sys_clk;

    paged_stack_unit #(.DISP_BYTES(8)) u_paged_stack_unit (
        .sys_clk(sys_clk), .srst(srst), .bankedMode(bankedMode), .maxMode(maxMode),
        .stackPageInput(stackPage), .expandPageIn(epIn), .indexXPageIn(xpIn),
        .indexYPageIn(ypIn), .pageLoad(pageLoad), .spLoad(spLoad),
        .spLoadValue(spLoadValue), .opCode(opCode), .opValid(opValid),
        .push8Data(push8Data), .pcIn(pcIn), .codeBankIn(codeBankIn), .flagsIn(flagsIn),
        .bulkRegsIn(bulkRegsIn), .memRdData(memRdData), .dataReq(dataReq),
        .dataWrite(dataWrite), .dataPageSel(dataPageSel), .dataAddr(dataAddr),
        .dataWrData(dataWrData), .opBusy(opBusy), .opDone(opDone), .memAddr(memAddr),
        .memWrData(memWrData), .memWr(memWr), .memRd(memRd), .stackPointer(stackPointer),
        .pcOut(pcOut), .codeBankOut(codeBankOut), .flagsOut(flagsOut), .pop8Data(pop8Data),
        .bulkRegsOut(bulkRegsOut), .restoreFlags(restoreFlags), .restoreBank(restoreBank),
        .dispRdData(), .segments(segments));

    stack_mem_model u_stack_mem_model (
        .sys_clk(sys_clk), .memAddr(memAddr), .memWrData(memWrData), .memWr(memWr),
        .memRd(memRd), .memRdData(memRdData));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_sim();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] peek(input logic [23:0] a);
        return u_stack_mem_model.mem.exists(int'(a)) ? u_stack_mem_model.mem[int'(a)] : 'x;
    endfunction : peek

    task automatic set_mode(input logic b, input logic m);
        @(posedge sys_clk);
        bankedMode <= b;
        maxMode <= m;
        pageLoad <= 1'b1;
        @(posedge sys_clk);
        pageLoad <= 1'b0;
    endtask : set_mode

    task automatic set_sp(input logic [15:0] v);
        @(posedge sys_clk);
        spLoad <= 1'b1;
        spLoadValue <= v;
        @(posedge sys_clk);
        spLoad <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(stackPointer, v);
    endtask : set_sp

    // operands ride with opValid; waits for the done pulse
    task automatic do_op(input stack_op_e op, input logic [15:0] pc, input logic [7:0] cb,
                         input logic [7:0] fl, input logic [63:0] b);
        int k;
        @(posedge sys_clk);
        opCode <= op;
        opValid <= 1'b1;
        pcIn <= pc;
        codeBankIn <= cb;
        flagsIn <= fl;
        bulkRegsIn <= b;
        push8Data <= b[7:0];
        @(posedge sys_clk);
        opValid <= 1'b0;
        for (k = 0; k < 60; k++) begin
            @(posedge sys_clk);
            #1;
            if (opDone === 1'b1) break;
        end
        if (k == 60) chk(1'b0, 1'b1);
    endtask : do_op

    task automatic data_wr(input page_sel_e sel, input logic [15:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        dataReq <= 1'b1;
        dataWrite <= 1'b1;
        dataPageSel <= sel;
        dataAddr <= a;
        dataWrData <= d;
        @(posedge sys_clk);
        dataReq <= 1'b0;
        dataWrite <= 1'b0;
        for (k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            if (memWr === 1'b1) break;
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : data_wr

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_push_pop();
        set_mode(1'b1, 1'b0);
        set_sp(16'h0000);
        do_op(OP_PUSH8, 16'h0, 8'h0, 8'h0, 64'hc3);
        chk(stackPointer, 16'hffff);
        chk(peek(24'h5affff), 8'hc3);
        do_op(OP_POP8, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(pop8Data, 8'hc3);
        chk(stackPointer, 16'h0000);
        $display("test push_pop done");
    endtask : test_push_pop

    task automatic test_call_ret();
        set_mode(1'b1, 1'b1);
        do_op(OP_CALL, 16'h1234, 8'h07, 8'h0, 64'h0);
        chk(stackPointer, 16'hfffd);
        chk({peek(24'h5affff), peek(24'h5afffe), peek(24'h5afffd)}, 24'h071234);
        do_op(OP_RET, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(restoreBank, 1'b1);
        chk({codeBankOut, pcOut}, 24'h071234);
        chk(stackPointer, 16'h0000);
        set_mode(1'b0, 1'b0);
        do_op(OP_CALL, 16'h2000, 8'h07, 8'h0, 64'h0);
        chk(stackPointer, 16'hfffe);
        chk({peek(24'h5affff), peek(24'h5afffe)}, 16'h2000);
        chk(peek(24'h5afffd), 8'h34);
        do_op(OP_SKIPRET, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(pcOut, 16'h2002);
        chk(stackPointer, 16'h0000);
        $display("test call_ret done");
    endtask : test_call_ret

    task automatic test_exc();
        set_mode(1'b1, 1'b1);
        do_op(OP_EXC, 16'h4321, 8'h03, 8'h9c, 64'h0);
        chk(stackPointer, 16'hfffc);
        chk(peek(24'h5afffc), 8'h9c);
        do_op(OP_EXCRET, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(restoreFlags, 1'b1);
        chk({codeBankOut, flagsOut, pcOut}, 32'h039c4321);
        set_mode(1'b1, 1'b0);
        do_op(OP_EXC, 16'h5555, 8'h03, 8'h21, 64'h0);
        chk(stackPointer, 16'hfffd);
        chk(peek(24'h5afffd), 8'h21);
        do_op(OP_EXCRET, 16'h0, 8'h0, 8'h0, 64'h0);
        chk({flagsOut, pcOut}, 24'h215555);
        chk(stackPointer, 16'h0000);
        $display("test exception done");
    endtask : test_exc

    task automatic test_bulk();
        set_mode(1'b1, 1'b0);
        do_op(OP_PUSHALL, 16'h0, 8'h0, 8'h0, 64'h0123456789abcdef);
        spAll = stackPointer;
        do_op(OP_POPALL, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(bulkRegsOut, 64'h0123456789abcdef);
        chk(stackPointer, 16'h0000);
        do_op(OP_PUSHALE, 16'h0, 8'h0, 8'h0, 64'hfedcba9876543210);
        chk(stackPointer < spAll, 1'b1);
        do_op(OP_POPALE, 16'h0, 8'h0, 8'h0, 64'h0);
        chk(bulkRegsOut, 64'hfedcba9876543210);
        chk(stackPointer, 16'h0000);
        $display("test bulk done");
    endtask : test_bulk

    task automatic test_data();
        page_sel_e sels [3] = '{PAGE_EXPAND, PAGE_IX, PAGE_IY};
        logic [7:0] pg;
        set_mode(1'b1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            pg = 8'h11 * (i + 1);
            data_wr(sels[i], 16'h4000 + 16'(i), 8'h80 + 8'(i));
            chk(peek({pg, 16'h4000 + 16'(i)}), 8'h80 + 8'(i));
        end
        set_mode(1'b0, 1'b0);
        data_wr(PAGE_IX, 16'h4100, 8'h5e);
        chk(peek(24'h004100), 8'h5e);
        // whole-byte writes only: dispRdData is left open here, so segments is checked instead
        data_wr(PAGE_EXPAND, 16'hff00, 8'ha5);
        data_wr(PAGE_EXPAND, 16'hff07, 8'h3c);
        chk(segments, 64'h3c000000000000a5);
        $display("test data done");
    endtask : test_data

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        test_push_pop();
        test_call_ret();
        test_exc();
        test_bulk();
        test_data();
        end_sim();
    end
endmodule : tb_paged_stack_unit

`default_nettype wire
